// ==== src/tcc_pkg.sv ====
// constants, field layouts and helpers for the timer capture block
package tcc_pkg;

    // ------------------------------------------------------------
    // block geometry
    // ------------------------------------------------------------
    localparam int         NCH          = 3;
    localparam int         CNT_W        = 16;
    localparam int         DIV_W        = 7;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;

    // ------------------------------------------------------------
    // register offsets inside a channel window and block registers
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_CCR      = 6'h00;
    localparam logic [5:0] OFF_CMR      = 6'h04;
    localparam logic [5:0] OFF_CV       = 6'h10;
    localparam logic [5:0] OFF_RA       = 6'h14;
    localparam logic [5:0] OFF_RB       = 6'h18;
    localparam logic [5:0] OFF_RC       = 6'h1C;
    localparam logic [5:0] OFF_SR       = 6'h20;
    localparam logic [5:0] OFF_IER      = 6'h24;
    localparam logic [5:0] OFF_IDR      = 6'h28;
    localparam logic [5:0] OFF_IMR      = 6'h2C;
    localparam logic [7:0] ADDR_BCR     = 8'hC0;
    localparam logic [7:0] ADDR_BMR     = 8'hC4;
    localparam logic [1:0] BLOCK_WIN    = 2'h3;

    // ------------------------------------------------------------
    // control register bits
    // ------------------------------------------------------------
    localparam int CCR_CLK_ON   = 0;
    localparam int CCR_CLK_OFF  = 1;
    localparam int CCR_SW_TRIG  = 2;
    localparam int BCR_SYNC     = 0;

    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int CMR_CLKSEL_LO  = 0;   // 3 bits, 0-4 internal, 5-7 ext
    localparam int CMR_INVERT     = 3;
    localparam int CMR_GATE_LO    = 4;   // 2 bits, 0 none, 1-3 ext in
    localparam int CMR_HALT       = 6;   // halt on b load / c match
    localparam int CMR_DISABLE    = 7;   // disable on b load / c match
    localparam int CMR_TRGEDG_LO  = 8;   // 2 bits edge code
    localparam int CMR_EVSEL_LO   = 10;  // capture: bit10 line sel
    localparam int CMR_EV_TRIG_EN = 12;
    localparam int CMR_C_TRIG     = 14;
    localparam int CMR_WAVE       = 15;
    localparam int CMR_LDA_LO     = 16;  // 2 bits edge code
    localparam int CMR_LDB_LO     = 18;  // 2 bits edge code
    localparam int CMR_W          = 20;
    localparam int BMR_W          = 6;   // 2 bits per ext clock input

    // ------------------------------------------------------------
    // status register bits
    // ------------------------------------------------------------
    localparam int SR_OVF     = 0;
    localparam int SR_LOVR    = 1;
    localparam int SR_CMATCH  = 4;
    localparam int SR_LOAD_A  = 5;
    localparam int SR_LOAD_B  = 6;
    localparam int SR_ETRIG   = 7;
    localparam int FLAG_W     = 8;
    localparam int SR_CLK_ON  = 16;
    localparam int SR_LINE_A  = 17;
    localparam int SR_LINE_B  = 18;

    // ------------------------------------------------------------
    // edge codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;
    localparam logic [CMR_W-1:0] CMR_RST = '0;
    localparam logic [15:0] CNT_RST     = 16'h0000;

    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic       prev,
                                      input logic       cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        unique case (code)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            EDGE_NONE: edge_hit = 1'b0;
        endcase
    endfunction

endpackage

// ==== src/tcc_timer_capture.sv ====
// three-channel 16-bit timer counter in capture mode with apb registers
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps

module tcc_timer_capture (
    input  wire logic                     clock_i,
    input  wire logic                     rst_i,
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [7:0]               paddr_i,
    input  wire logic [31:0]              pwdata_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    input  wire logic                     slow_clock_i,
    input  wire logic [tcc_pkg::NCH-1:0]  ext_clock_pin_i,
    input  wire logic [tcc_pkg::NCH-1:0]  io_line_a_i,
    output logic      [tcc_pkg::NCH-1:0]  io_line_a_o,
    output logic      [tcc_pkg::NCH-1:0]  io_line_a_oe_o,
    input  wire logic [tcc_pkg::NCH-1:0]  io_line_b_i,
    output logic      [tcc_pkg::NCH-1:0]  io_line_b_o,
    output logic      [tcc_pkg::NCH-1:0]  io_line_b_oe_o,
    output logic      [tcc_pkg::NCH-1:0]  irq_o
);
    import tcc_pkg::*;

    // ------------------------------------------------------------
    // shared state
    // ------------------------------------------------------------
    logic [DIV_W-1:0]  div_r;
    logic [DIV_W-1:0]  div_nxt;
    logic [BMR_W-1:0]  bmr_r;
    logic [BMR_W-1:0]  bmr_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              pready_r;
    logic              pready_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic [NCH-1:0]    xc;
    logic [NCH-1:0]    la_lvl;

    logic [15:0]       cv_r    [NCH];
    logic [15:0]       ra_r    [NCH];
    logic [15:0]       rb_r    [NCH];
    logic [15:0]       rc_r    [NCH];
    logic [CMR_W-1:0]  cmr_r   [NCH];
    logic [FLAG_W-1:0] flags_r [NCH];
    logic [FLAG_W-1:0] imr_r   [NCH];
    logic [NCH-1:0]    en_r;

    // ------------------------------------------------------------
    // bus strobes, taken at the completing access edge
    // ------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic [1:0] win;
    logic [5:0] off;
    logic       sync_cmd;

    assign acc      = psel_i & penable_i & pready_r;
    assign wr       = acc & pwrite_i;
    assign rd       = acc & ~pwrite_i;
    assign win      = paddr_i[7:6];
    assign off      = paddr_i[5:0];
    assign sync_cmd = wr & (paddr_i == ADDR_BCR) & pwdata_i[BCR_SYNC];

    // ------------------------------------------------------------
    // external clock inputs and chaining
    // ------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < NCH; k++) begin : g_xc
            always_comb begin
                unique case (bmr_r[2*k +: 2])
                    2'h0: xc[k] = ext_clock_pin_i[k];
                    2'h1: xc[k] = 1'b0;
                    2'h2: xc[k] = la_lvl[(k + 1) % NCH];
                    2'h3: xc[k] = la_lvl[(k + 2) % NCH];
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // divider, block mode and apb slave
    // ------------------------------------------------------------
    logic [31:0] rdata;
    logic        hit;

    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        if (win == BLOCK_WIN) begin
            if (paddr_i == ADDR_BMR) begin
                rdata = {26'h000_0000, bmr_r};
            end else if (paddr_i != ADDR_BCR) begin
                hit = 1'b0;
            end
        end else begin
            unique case (off)
                OFF_CCR, OFF_IER, OFF_IDR: rdata = 32'h0000_0000;
                OFF_CMR: rdata = {12'h000, cmr_r[win]};
                OFF_CV:  rdata = {16'h0000, cv_r[win]};
                OFF_RA:  rdata = {16'h0000, ra_r[win]};
                OFF_RB:  rdata = {16'h0000, rb_r[win]};
                OFF_RC:  rdata = {16'h0000, rc_r[win]};
                OFF_SR:  rdata = {13'h0000, io_line_b_i[win], la_lvl[win],
                                  en_r[win], 8'h00, flags_r[win]};
                OFF_IMR: rdata = {24'h00_0000, imr_r[win]};
                default: hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        div_nxt     = div_r + 7'h01;
        bmr_nxt     = bmr_r;
        if (wr && paddr_i == ADDR_BMR) begin
            bmr_nxt = pwdata_i[BMR_W-1:0];
        end
        // one wait-free access: answer is set up during the setup cycle
        pready_nxt  = psel_i & ~penable_i;
        pslverr_nxt = psel_i & ~penable_i & ~hit;
        prdata_nxt  = prdata_r;
        if (psel_i && !penable_i && !pwrite_i) begin
            prdata_nxt = hit ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            div_r     <= '0;
            bmr_r     <= '0;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            div_r     <= div_nxt;
            bmr_r     <= bmr_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            logic [15:0]       cv_n;
            logic [15:0]       ra_n;
            logic [15:0]       rb_n;
            logic [15:0]       rc_n;
            logic [CMR_W-1:0]  cmr_n;
            logic [FLAG_W-1:0] flags_n;
            logic [FLAG_W-1:0] imr_n;
            logic              en_n;
            logic              run_r;
            logic              run_n;
            logic              pend_r;
            logic              pend_n;
            logic              a_done_r;
            logic              a_done_n;
            logic              ra_new_r;
            logic              ra_new_n;
            logic              rb_new_r;
            logic              rb_new_n;
            logic              clk_prev_r;
            logic              la_prev_r;
            logic              ev_prev_r;
            logic              irq_r;
            logic              oe_a_r;
            logic              oe_b_r;
            logic              lvl;
            logic              tick;
            logic              ev_sig;
            logic              ext_trig;
            logic              trig;
            logic              wave;
            logic              cmatch;
            logic              my_wr;
            logic              my_rd;

            assign la_lvl[i] = cmr_r[i][CMR_WAVE] ? io_line_a_o[i]
                                                  : io_line_a_i[i];

            always_comb begin
                cv_n     = cv_r[i];
                ra_n     = ra_r[i];
                rb_n     = rb_r[i];
                rc_n     = rc_r[i];
                cmr_n    = cmr_r[i];
                imr_n    = imr_r[i];
                en_n     = en_r[i];
                run_n    = run_r;
                pend_n   = pend_r;
                a_done_n = a_done_r;
                ra_new_n = ra_new_r;
                rb_new_n = rb_new_r;
                my_wr    = wr & (win == 2'(i));
                my_rd    = rd & (win == 2'(i));
                wave     = cmr_r[i][CMR_WAVE];
                // clock select, invert, gate; inputs assumed slow enough
                lvl  = 1'({xc, slow_clock_i, div_r[6], div_r[4], div_r[2],
                           div_r[0]} >> cmr_r[i][CMR_CLKSEL_LO +: 3])
                       ^ cmr_r[i][CMR_INVERT];
                tick = lvl & ~clk_prev_r
                       & 1'({xc, 1'b1} >> cmr_r[i][CMR_GATE_LO +: 2]);
                // one edge detector serves the chosen event source
                if (wave) begin
                    ev_sig   = 1'({xc, io_line_b_i[i]}
                                  >> cmr_r[i][CMR_EVSEL_LO +: 2]);
                    ext_trig = edge_hit(cmr_r[i][CMR_TRGEDG_LO +: 2],
                                        ev_prev_r, ev_sig)
                               & cmr_r[i][CMR_EV_TRIG_EN];
                end else begin
                    ev_sig   = cmr_r[i][CMR_EVSEL_LO] ? la_lvl[i]
                                                      : io_line_b_i[i];
                    ext_trig = edge_hit(cmr_r[i][CMR_TRGEDG_LO +: 2],
                                        ev_prev_r, ev_sig);
                end
                trig = ext_trig | sync_cmd
                       | (my_wr & off == OFF_CCR
                          & pwdata_i[CCR_SW_TRIG]);
                cmatch = en_r[i] & run_r & tick & (cv_r[i] == rc_r[i]);
                // clear only what the read returned, so later sets survive
                flags_n = (my_rd && off == OFF_SR)
                          ? flags_r[i] & ~prdata_r[FLAG_W-1:0] : flags_r[i];
                if (my_rd && off == OFF_RA) begin
                    ra_new_n = 1'b0;
                end
                if (my_rd && off == OFF_RB) begin
                    rb_new_n = 1'b0;
                end
                if (trig) begin
                    pend_n   = 1'b1;
                    run_n    = 1'b1;
                    a_done_n = 1'b0;
                end
                flags_n[SR_ETRIG] = flags_n[SR_ETRIG] | ext_trig;
                if (tick && en_r[i] && run_r) begin
                    if (pend_r || (cmatch && cmr_r[i][CMR_C_TRIG])) begin
                        cv_n   = CNT_RST;
                        pend_n = trig;
                    end else begin
                        cv_n = cv_r[i] + 16'h0001;
                        if (cv_r[i] == CNT_MAX) begin
                            flags_n[SR_OVF] = 1'b1;
                        end
                    end
                end
                if (cmatch) begin
                    flags_n[SR_CMATCH] = 1'b1;
                    if (wave && cmr_r[i][CMR_HALT]) begin
                        run_n = 1'b0;
                    end
                    if (wave && cmr_r[i][CMR_DISABLE]) begin
                        en_n = 1'b0;
                    end
                end
                // capture loads alternate A then B
                if (!wave && !a_done_r
                    && edge_hit(cmr_r[i][CMR_LDA_LO +: 2], la_prev_r,
                                la_lvl[i])) begin
                    ra_n     = cv_r[i];
                    a_done_n = 1'b1;
                    flags_n[SR_LOAD_A] = 1'b1;
                    flags_n[SR_LOVR]   = flags_n[SR_LOVR] | ra_new_r;
                    ra_new_n = 1'b1;
                end
                if (!wave && a_done_r
                    && edge_hit(cmr_r[i][CMR_LDB_LO +: 2], la_prev_r,
                                la_lvl[i])) begin
                    rb_n     = cv_r[i];
                    a_done_n = 1'b0;
                    flags_n[SR_LOAD_B] = 1'b1;
                    flags_n[SR_LOVR]   = flags_n[SR_LOVR] | rb_new_r;
                    rb_new_n = 1'b1;
                    if (cmr_r[i][CMR_HALT]) begin
                        run_n = 1'b0;
                    end
                    if (cmr_r[i][CMR_DISABLE]) begin
                        en_n = 1'b0;
                    end
                end
                if (my_wr) begin
                    unique case (off)
                        OFF_CMR: cmr_n = pwdata_i[CMR_W-1:0];
                        OFF_RC:  rc_n  = pwdata_i[15:0];
                        OFF_RA:  ra_n  = wave ? pwdata_i[15:0] : ra_n;
                        OFF_RB:  rb_n  = wave ? pwdata_i[15:0] : rb_n;
                        OFF_IER: imr_n = imr_r[i] | pwdata_i[FLAG_W-1:0];
                        OFF_IDR: imr_n = imr_r[i] & ~pwdata_i[FLAG_W-1:0];
                        default: imr_n = imr_n;
                    endcase
                end
                if (my_wr && off == OFF_CCR) begin
                    if (pwdata_i[CCR_CLK_ON]) begin
                        en_n = 1'b1;
                    end
                    // disable outranks enable written together
                    if (pwdata_i[CCR_CLK_OFF]) begin
                        en_n = 1'b0;
                    end
                end
                // start and stop mean nothing while disabled
                run_n = run_n & en_n & en_r[i];
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    cv_r[i]    <= CNT_RST;
                    ra_r[i]    <= CNT_RST;
                    rb_r[i]    <= CNT_RST;
                    rc_r[i]    <= CNT_RST;
                    cmr_r[i]   <= CMR_RST;
                    flags_r[i] <= '0;
                    imr_r[i]   <= '0;
                    en_r[i]    <= 1'b0;
                    run_r      <= 1'b0;
                    pend_r     <= 1'b0;
                    a_done_r   <= 1'b0;
                    ra_new_r   <= 1'b0;
                    rb_new_r   <= 1'b0;
                    clk_prev_r <= 1'b0;
                    la_prev_r  <= 1'b0;
                    ev_prev_r  <= 1'b0;
                    irq_r      <= 1'b0;
                    oe_a_r     <= 1'b0;
                    oe_b_r     <= 1'b0;
                    io_line_a_o[i] <= 1'b0;
                    io_line_b_o[i] <= 1'b0;
                end else begin
                    cv_r[i]    <= cv_n;
                    ra_r[i]    <= ra_n;
                    rb_r[i]    <= rb_n;
                    rc_r[i]    <= rc_n;
                    cmr_r[i]   <= cmr_n;
                    flags_r[i] <= flags_n;
                    imr_r[i]   <= imr_n;
                    en_r[i]    <= en_n;
                    run_r      <= run_n;
                    pend_r     <= pend_n;
                    a_done_r   <= a_done_n;
                    ra_new_r   <= ra_new_n;
                    rb_new_r   <= rb_new_n;
                    clk_prev_r <= lvl;
                    la_prev_r  <= la_lvl[i];
                    ev_prev_r  <= ev_sig;
                    irq_r      <= |(flags_n & imr_n);
                    oe_a_r     <= cmr_n[CMR_WAVE];
                    oe_b_r     <= cmr_n[CMR_WAVE]
                                  & (cmr_n[CMR_EVSEL_LO +: 2] != 2'h0);
                    // waveform drive levels belong to the output controller
                    io_line_a_o[i] <= 1'b0;
                    io_line_b_o[i] <= 1'b0;
                end
            end

            assign irq_o[i]          = irq_r;
            assign io_line_a_oe_o[i] = oe_a_r;
            assign io_line_b_oe_o[i] = oe_b_r;
        end
    endgenerate

endmodule

// ==== verif/tcc_ext_src.sv ====
// far-side model: external clock pins and line b source
`timescale 1ns/1ps
module tcc_ext_src (
    input  wire logic       clock_i,
    input  wire logic [7:0] edges_i,
    input  wire logic       start_i,
    output logic      [2:0] pin_o
);
    logic [7:0] left_r = '0;
    logic [1:0] ph_r   = '0;
    logic       lvl_r  = 1'b0;
    // each level held 3 master cycles, period 6
    always @(posedge clock_i) begin
        if (start_i) begin
            left_r <= edges_i;
            ph_r   <= '0;
        end else if (left_r != 0 || lvl_r) begin
            ph_r <= (ph_r == 2'd2) ? 2'd0 : ph_r + 2'd1;
            if (ph_r == 2'd2) begin
                lvl_r <= ~lvl_r;
                if (!lvl_r) left_r <= left_r - 8'd1;
            end
        end
    end
    // stands low between bursts
    assign pin_o = {3{lvl_r}};
endmodule

// ==== verif/tcc_timer_capture_monitor.sv ====
// port checker for the timer capture block
`timescale 1ns/1ps
module tcc_timer_capture_monitor (
    input wire logic                    clock_i,
    input wire logic                    rst_i,
    input wire logic                    psel_i,
    input wire logic                    penable_i,
    input wire logic                    pwrite_i,
    input wire logic [7:0]              paddr_i,
    input wire logic [31:0]             pwdata_i,
    input wire logic [31:0]             prdata_o,
    input wire logic                    pready_o,
    input wire logic                    pslverr_o,
    input wire logic [tcc_pkg::NCH-1:0] io_line_a_oe_o,
    input wire logic [tcc_pkg::NCH-1:0] io_line_b_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire acc = psel_i & penable_i & pready_o;
    wire rd  = acc & !pwrite_i;
    wire wv  = acc & pwrite_i & (paddr_i == 8'h04) & pwdata_i[15];
    AST_READY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_HOLE_ERR: assert property (acc && paddr_i[5:0] == 6'h08 |-> pslverr_o)
        else $error("reserved offset accepted");
    AST_WO_ZERO: assert property (rd && paddr_i[5:0] == 6'h00
        |-> prdata_o == 32'h0000_0000) else $error("write-only read not 0");
    AST_CV_WIDTH: assert property (rd && paddr_i == 8'h10
        |-> prdata_o[31:16] == 16'h0000) else $error("counter above 16 bits");
    AST_B_NEEDS_A: assert property ((io_line_b_oe_o & ~io_line_a_oe_o) == '0)
        else $error("line b out in capture");
    AST_A_OE_CAUSE: assert property ($rose(io_line_a_oe_o[0])
        |-> $past(wv) || $past(wv, 2)) else $error("line a out uncaused");
endmodule
bind tcc_timer_capture tcc_timer_capture_monitor tcc_timer_capture_monitor_i (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .io_line_a_oe_o(io_line_a_oe_o), .io_line_b_oe_o(io_line_b_oe_o));

// ==== verif/testbench.sv ====
// self-checking bench for the timer capture block
`timescale 1ns/1ps
module testbench;
    import tcc_pkg::*;
    logic        clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
    logic        pwrite_i = 0, pready_o, pslverr_o, er, start = 0;
    logic [7:0]  paddr_i = '0, edges = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic [2:0]  line_a = '0, pin, oe_a, irq;
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    localparam logic [40:0] ROWS [12] = '{{8'h04, 33'h0}, {8'h10, 33'h0},
        {8'h14, 33'h0}, {8'h18, 33'h0}, {8'h1C, 33'h0}, {8'h20, 33'h0},
        {8'h2C, 33'h0}, {8'hC4, 33'h0}, {8'h00, 33'h0}, {8'h08, 33'h1},
        {8'h34, 33'h1}, {8'hC8, 33'h1}};
    tcc_ext_src tcc_ext_src_i (.clock_i(clock_i), .edges_i(edges),
        .start_i(start), .pin_o(pin));
    tcc_timer_capture tcc_timer_capture_i (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .slow_clock_i(1'b0),
        .ext_clock_pin_i(pin), .io_line_a_i(line_a), .io_line_a_o(),
        .io_line_a_oe_o(oe_a), .io_line_b_i(pin), .io_line_b_o(),
        .io_line_b_oe_o(), .irq_o(irq));
    initial forever #25 clock_i = ~clock_i;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) @(posedge clock_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clock_i);
    endtask
    task automatic burst(input int k);
        edges <= 8'(k);
        start <= 1;
        @(posedge clock_i);
        start <= 0;
        repeat (k * 6 + 10) @(posedge clock_i);
    endtask
    task automatic pulse_a();
        line_a[0] <= 1;
        repeat (4) @(posedge clock_i);
        line_a[0] <= 0;
        repeat (4) @(posedge clock_i);
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 0;
        @(posedge clock_i);
        foreach (ROWS[i]) begin
            apb(0, ROWS[i][40:33], 0);
            chk("reset value", ROWS[i][32:1], rd);
            chk("slave error", {31'b0, ROWS[i][0]}, {31'b0, er});
        end
        $display("test reset values done");
        apb(1, 8'h04, 32'h0000_8000);
        chk("line a oe", 1, {31'b0, oe_a[0]});
        apb(1, 8'h04, 32'h0009_0005);
        apb(1, 8'h00, 32'h0000_0001);
        apb(1, 8'h00, 32'h0000_0004);
        burst(5);
        apb(0, 8'h10, 0);
        chk("count after trigger", 32'h0000_0004, rd);
        apb(0, 8'h20, 0);
        chk("clock on", 1, {31'b0, rd[SR_CLK_ON]});
        apb(1, 8'h00, 32'h0000_0002);
        burst(3);
        apb(0, 8'h10, 0);
        chk("count disabled", 32'h0000_0004, rd);
        $display("test count done");
        pulse_a();
        apb(0, 8'h14, 0);
        chk("capture a", 32'h0000_0004, rd);
        apb(0, 8'h18, 0);
        chk("capture b", 32'h0000_0004, rd);
        pulse_a();
        pulse_a();
        apb(0, 8'h20, 0);
        chk("overrun", 1, {31'b0, rd[SR_LOVR]});
        apb(1, 8'h04, 32'h0004_0005);
        pulse_a();
        apb(0, 8'h20, 0);
        chk("b without a", 0, {31'b0, rd[SR_LOAD_B]});
        $display("test capture done");
        apb(1, 8'h00, 32'h0000_0001);
        apb(1, 8'hC0, 32'h0000_0001);
        burst(3);
        apb(0, 8'h10, 0);
        chk("sync trigger", 32'h0000_0002, rd);
        $display("test sync done");
        apb(1, 8'h1C, 32'h0000_0002);
        apb(1, 8'h24, 32'h0000_0010);
        apb(1, 8'h04, 32'h0000_4005);
        apb(1, 8'h00, 32'h0000_0004);
        burst(5);
        chk("irq", 1, {31'b0, irq[0]});
        apb(0, 8'h10, 0);
        chk("c match trigger", 32'h0000_0001, rd);
        apb(1, 8'hC4, 32'h0000_0004);
        apb(1, 8'h04, 32'h0000_0025);
        apb(1, 8'h00, 32'h0000_0004);
        burst(3);
        apb(0, 8'h10, 0);
        chk("gated count", 32'h0000_0001, rd);
        apb(1, 8'h04, 32'h0000_0105);
        burst(3);
        apb(0, 8'h10, 0);
        chk("edge trigger", 32'h0000_0000, rd);
        $display("test trigger done");
        complete_run();
    end
endmodule
